// ==== sec_pkg.sv ====
// sec_pkg: constants and types of the sample error checker.
// assumes one register port on mclk and a free-running link clock.
// Functional notes
// R1: control bit 7 switches compare logic on
// R2: control bit 6 clears all error flags
// R3: bit 5 auto mode, clears after eight passes
// R4: auto mode sets bit 2 after eight matches
// R5: auto mode sets bit 1 on miscompare
// R6: bit 0 set on any miscompare
// R7: software writes zero to bits 4, 3
// R8: port0 rising errors, low byte readable
// R9: port0 rising bits 13:8, upper two zero
// R10: port1 rising errors, low and high registers
// R11: control register resets to all zeros
// R12: falling-edge errors for both ports kept too
// R13: error flags sticky until clear or autoclear
// R14: expected samples come from outside source
package sec_pkg;
  localparam int SEC_SAMPLE_W = 14;
  localparam int SEC_ADDR_W = 8;
  localparam int SEC_LOW_W = 8;
  localparam int SEC_CNT_W = 4;
  localparam logic [SEC_CNT_W-1:0] SEC_PASS_SETS = 4'h8;
  // register offsets
  localparam logic [7:0] SEC_A_CTRL = 8'h50;
  localparam logic [7:0] SEC_A_P0RL = 8'h51;
  localparam logic [7:0] SEC_A_P0RH = 8'h52;
  localparam logic [7:0] SEC_A_P1RL = 8'h53;
  localparam logic [7:0] SEC_A_P1RH = 8'h54;
  localparam logic [7:0] SEC_A_P0FL = 8'h55;
  localparam logic [7:0] SEC_A_P0FH = 8'h56;
  localparam logic [7:0] SEC_A_P1FL = 8'h57;
  localparam logic [7:0] SEC_A_P1FH = 8'h58;
  localparam logic [7:0] SEC_CTRL_RST = 8'h00;
  // control field positions
  localparam int SEC_B_ON = 7;
  localparam int SEC_B_CLR = 6;
  localparam int SEC_B_AUTO = 5;
  localparam int SEC_B_PASS = 2;
  localparam int SEC_B_AFAIL = 1;
  localparam int SEC_B_SFAIL = 0;

  typedef struct packed {
    logic [SEC_SAMPLE_W-1:0] p0r;
    logic [SEC_SAMPLE_W-1:0] p0f;
    logic [SEC_SAMPLE_W-1:0] p1r;
    logic [SEC_SAMPLE_W-1:0] p1f;
  } sec_lanes_s;

  typedef struct packed {
    logic pass8;
    sec_lanes_s err;
  } sec_bundle_s;

  typedef struct packed {
    logic on;
    logic auto_on;
    logic pass;
    logic afail;
    logic sfail;
    sec_lanes_s err;
    logic req_s1;
    logic req_s2;
    logic req_seen;
    logic ack;
    logic [SEC_LOW_W-1:0] rdata;
  } sec_main_s;

  typedef struct packed {
    logic [1:0] cfg_s1;
    logic [1:0] cfg_s2;
    logic ack_s1;
    logic ack_s2;
    logic req;
    logic [SEC_CNT_W-1:0] cnt;
    logic pend_v;
    sec_bundle_s pend;
    sec_bundle_s xfer;
  } sec_link_s;
endpackage

// ==== sec_checker.sv ====
// sec_checker: compares dual-port ddr samples against expected words
// and keeps sticky per-bit error flags behind an 8-bit register port.
// assumes samples and expected words are already captured on dclk_i.
`timescale 1ns/1ps
module sec_checker
  import sec_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic dclk_i,
  input wire sec_lanes_s sample_i,
  input wire sec_lanes_s expect_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [SEC_ADDR_W-1:0] reg_addr_i,
  input wire logic [SEC_LOW_W-1:0] reg_wdata_i,
  output logic [SEC_LOW_W-1:0] reg_rdata_o
);

  sec_main_s m_r;
  sec_main_s m_nxt;
  sec_link_s l_r;
  sec_link_s l_nxt;
  sec_lanes_s miss;
  logic cmp_on;
  logic ev;
  logic clr;

  // one status byte of a 14-bit vector; upper bits of high half read 0
  function automatic logic [SEC_LOW_W-1:0] err_byte(
    input logic [SEC_SAMPLE_W-1:0] v,
    input logic hi
  );
    err_byte = hi ? SEC_LOW_W'(v[SEC_SAMPLE_W-1:SEC_LOW_W])
                  : v[SEC_LOW_W-1:0];
  endfunction

  // link side: compare, count passing sets, hand bundles over
  always_comb begin
    l_nxt = l_r;
    // control bits change rarely and each stands alone, so a plain
    // two-stage sync per bit is enough; no pairing between them needed
    l_nxt.cfg_s1 = {m_r.auto_on, m_r.on};
    l_nxt.cfg_s2 = l_r.cfg_s1;
    l_nxt.ack_s1 = m_r.ack;
    l_nxt.ack_s2 = l_r.ack_s1;
    cmp_on = |l_r.cfg_s2; // [R1]
    miss = sample_i ^ expect_i; // [R14]
    if (!cmp_on) begin
      l_nxt.cnt = '0;
    end else if (|miss) begin
      // errors gather until the main side takes them
      l_nxt.pend.err = l_r.pend.err | miss; // [R13]
      l_nxt.pend_v = 1'b1;
      l_nxt.cnt = '0;
    end else if (l_r.cfg_s2[1]) begin
      if (l_r.cnt == SEC_PASS_SETS - 4'h1) begin
        // eight good sets wipe what came before them
        l_nxt.cnt = '0;
        l_nxt.pend.pass8 = 1'b1; // [R3]
        l_nxt.pend.err = '0;
        l_nxt.pend_v = 1'b1;
      end else begin
        l_nxt.cnt = l_r.cnt + 4'h1;
      end
    end
    // xfer holds still while a toggle is in flight; the main side
    // reads it as a whole word, so this hold stands in for a gray code
    if (l_r.req == l_r.ack_s2 && l_nxt.pend_v) begin
      l_nxt.xfer = l_nxt.pend;
      l_nxt.req = ~l_r.req;
      l_nxt.pend = '0;
      l_nxt.pend_v = 1'b0;
    end
  end

  always_ff @(posedge dclk_i or posedge reset_i) begin
    if (reset_i) begin
      l_r <= '0;
    end else begin
      l_r <= l_nxt;
    end
  end

  // main side: register port and flag update
  // req is synced twice, req_seen keeps the last level taken, and ack
  // echoes it back so the link side knows the bundle has been read
  always_comb begin
    m_nxt = m_r;
    m_nxt.req_s1 = l_r.req;
    m_nxt.req_s2 = m_r.req_s1;
    m_nxt.req_seen = m_r.req_s2;
    ev = m_r.req_s2 != m_r.req_seen;
    m_nxt.ack = m_r.req_seen;
    clr = 1'b0;
    if (reg_wr_i && reg_addr_i == SEC_A_CTRL) begin
      // bits 4 and 3 are dropped, written data there is ignored
      m_nxt.on = reg_wdata_i[SEC_B_ON]; // [R1] [R7]
      m_nxt.auto_on = reg_wdata_i[SEC_B_AUTO]; // [R3]
      m_nxt.pass = reg_wdata_i[SEC_B_PASS];
      clr = reg_wdata_i[SEC_B_CLR];
    end
    if (clr) begin
      m_nxt.err = '0; // [R2]
      m_nxt.afail = 1'b0;
      m_nxt.sfail = 1'b0;
    end
    // arriving errors are applied after the clear, so set wins
    if (ev) begin
      if (l_r.xfer.pass8 && m_r.auto_on) begin
        m_nxt.err = '0; // [R3]
        m_nxt.afail = 1'b0;
        m_nxt.sfail = 1'b0;
        m_nxt.pass = 1'b1; // [R4]
      end
      if (|l_r.xfer.err) begin
        m_nxt.err = m_nxt.err | l_r.xfer.err; // [R13]
        m_nxt.sfail = 1'b1; // [R6]
        if (m_r.auto_on) begin
          m_nxt.afail = 1'b1; // [R5]
          m_nxt.pass = 1'b0;
        end
      end
    end
    // read data is registered; unmapped addresses return zero
    if (reg_rd_i) begin
      if (reg_addr_i == SEC_A_CTRL) begin
        m_nxt.rdata = '0;
        m_nxt.rdata[SEC_B_ON] = m_r.on;
        m_nxt.rdata[SEC_B_AUTO] = m_r.auto_on;
        m_nxt.rdata[SEC_B_PASS] = m_r.pass;
        m_nxt.rdata[SEC_B_AFAIL] = m_r.afail;
        m_nxt.rdata[SEC_B_SFAIL] = m_r.sfail;
      end else if (reg_addr_i == SEC_A_P0RL) begin
        m_nxt.rdata = err_byte(m_r.err.p0r, 1'b0); // [R8]
      end else if (reg_addr_i == SEC_A_P0RH) begin
        m_nxt.rdata = err_byte(m_r.err.p0r, 1'b1); // [R9]
      end else if (reg_addr_i == SEC_A_P1RL) begin
        m_nxt.rdata = err_byte(m_r.err.p1r, 1'b0); // [R10]
      end else if (reg_addr_i == SEC_A_P1RH) begin
        m_nxt.rdata = err_byte(m_r.err.p1r, 1'b1); // [R10]
      end else if (reg_addr_i == SEC_A_P0FL) begin
        m_nxt.rdata = err_byte(m_r.err.p0f, 1'b0); // [R12]
      end else if (reg_addr_i == SEC_A_P0FH) begin
        m_nxt.rdata = err_byte(m_r.err.p0f, 1'b1); // [R12]
      end else if (reg_addr_i == SEC_A_P1FL) begin
        m_nxt.rdata = err_byte(m_r.err.p1f, 1'b0); // [R12]
      end else if (reg_addr_i == SEC_A_P1FH) begin
        m_nxt.rdata = err_byte(m_r.err.p1f, 1'b1); // [R12]
      end else begin
        m_nxt.rdata = '0;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      m_r <= '0; // [R11]
    end else begin
      m_r <= m_nxt;
    end
  end

  assign reg_rdata_o = m_r.rdata;

  sequence good_auto_set;
    cmp_on && l_r.cfg_s2[1] && !(|miss);
  endsequence

  sequence err_arrives;
    ev && |l_r.xfer.err;
  endsequence

  chk_compare_off: assert property ( // [R1]
    @(posedge dclk_i) disable iff (reset_i)
    !cmp_on |=> l_r.cnt == '0 &&
        (l_r.pend.err & ~$past(l_r.pend.err)) == '0)
    else $error("compare ran while disabled");

  chk_eighth_pass: assert property ( // [R3]
    @(posedge dclk_i) disable iff (reset_i)
    (l_r.cnt == SEC_PASS_SETS - 4'h1) ##0 good_auto_set
    |=> (l_r.pend.pass8 || l_r.xfer.pass8) && l_r.cnt == '0)
    else $error("eighth good set not reported");

  chk_flags_clear: assert property ( // [R2]
    @(posedge mclk_i) disable iff (reset_i)
    clr && !ev |=> m_r.err == '0 && !m_r.sfail && !m_r.afail)
    else $error("clear left a flag set");

  chk_auto_pass: assert property ( // [R4]
    @(posedge mclk_i) disable iff (reset_i)
    ev && l_r.xfer.pass8 && m_r.auto_on && l_r.xfer.err == '0
    |=> m_r.pass && m_r.err == '0)
    else $error("auto pass not reported");

  chk_auto_fail: assert property ( // [R5]
    @(posedge mclk_i) disable iff (reset_i)
    err_arrives ##0 m_r.auto_on |=> m_r.afail && !m_r.pass)
    else $error("auto fail not raised");

  chk_any_fail: assert property ( // [R6]
    @(posedge mclk_i) disable iff (reset_i)
    err_arrives |=> m_r.sfail ##1 m_r.sfail || $past(clr))
    else $error("fail flag missing");

  chk_sticky_bits: assert property ( // [R13]
    @(posedge mclk_i) disable iff (reset_i)
    !clr && !ev |=> (m_r.err & $past(m_r.err)) == $past(m_r.err))
    else $error("error flag dropped");

  chk_high_zero: assert property ( // [R9]
    @(posedge mclk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == SEC_A_P0RH
    |=> reg_rdata_o[7:6] == 2'h0 &&
        reg_rdata_o[5:0] == $past(m_r.err.p0r[13:8]))
    else $error("high byte readback wrong");

  chk_low_read: assert property ( // [R8]
    @(posedge mclk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == SEC_A_P0RL
    |=> reg_rdata_o == $past(m_r.err.p0r[7:0]))
    else $error("low byte readback wrong");

  // remaining readback paths; high halves always pad with zeros
  chk_p1r_low: assert property ( // [R10]
    @(posedge mclk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == SEC_A_P1RL
    |=> reg_rdata_o == $past(m_r.err.p1r[SEC_LOW_W-1:0]))
    else $error("port1 rising low byte wrong");

  chk_p1r_high: assert property ( // [R10]
    @(posedge mclk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == SEC_A_P1RH
    |=> reg_rdata_o ==
        SEC_LOW_W'($past(m_r.err.p1r[SEC_SAMPLE_W-1:SEC_LOW_W])))
    else $error("port1 rising high byte wrong");

  chk_p0f_low: assert property ( // [R12]
    @(posedge mclk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == SEC_A_P0FL
    |=> reg_rdata_o == $past(m_r.err.p0f[SEC_LOW_W-1:0]))
    else $error("port0 falling low byte wrong");

  chk_p0f_high: assert property ( // [R12]
    @(posedge mclk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == SEC_A_P0FH
    |=> reg_rdata_o ==
        SEC_LOW_W'($past(m_r.err.p0f[SEC_SAMPLE_W-1:SEC_LOW_W])))
    else $error("port0 falling high byte wrong");

  chk_p1f_low: assert property ( // [R12]
    @(posedge mclk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == SEC_A_P1FL
    |=> reg_rdata_o == $past(m_r.err.p1f[SEC_LOW_W-1:0]))
    else $error("port1 falling low byte wrong");

  chk_p1f_high: assert property ( // [R12]
    @(posedge mclk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == SEC_A_P1FH
    |=> reg_rdata_o ==
        SEC_LOW_W'($past(m_r.err.p1f[SEC_SAMPLE_W-1:SEC_LOW_W])))
    else $error("port1 falling high byte wrong");

  // control readback: the clear bit and reserved bits read as zero
  chk_ctrl_read: assert property ( // [R2]
    @(posedge mclk_i) disable iff (reset_i)
    reg_rd_i && reg_addr_i == SEC_A_CTRL
    |=> reg_rdata_o[SEC_B_CLR] == 1'b0 &&
        reg_rdata_o[SEC_B_AUTO-1:SEC_B_PASS+1] == 2'h0 &&
        reg_rdata_o[SEC_B_ON] == $past(m_r.on) &&
        reg_rdata_o[SEC_B_SFAIL] == $past(m_r.sfail))
    else $error("control readback wrong");

  // read data stands until the next read strobe
  chk_rdata_hold: assert property ( // [R8]
    @(posedge mclk_i) disable iff (reset_i)
    !reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without a read");

  // plain mode must never raise the auto fail flag
  chk_plain_afail: assert property ( // [R5]
    @(posedge mclk_i) disable iff (reset_i)
    err_arrives ##0 !m_r.auto_on && !clr |=> $stable(m_r.afail))
    else $error("auto fail raised in plain mode");

  // a miscompare must reach the pending or the in-flight bundle
  chk_miss_kept: assert property ( // [R14]
    @(posedge dclk_i) disable iff (reset_i)
    cmp_on && |miss
    |=> ((l_r.pend.err | l_r.xfer.err) & $past(miss)) == $past(miss))
    else $error("miscompare lost on the link side");

  // the bundle must not move while the main side may still read it
  chk_xfer_stable: assert property ( // [R13]
    @(posedge dclk_i) disable iff (reset_i)
    l_r.req != l_r.ack_s2 |=> $stable(l_r.xfer))
    else $error("bundle changed during handover");

  // reset seen on two edges in a row must have wiped all state
  sequence reset_held;
    reset_i ##1 reset_i;
  endsequence

  chk_reset_main: assert property ( // [R11]
    @(posedge mclk_i) reset_held |-> m_r == '0)
    else $error("register side not reset");

  chk_reset_link: assert property ( // [R11]
    @(posedge dclk_i) reset_held |-> l_r == '0)
    else $error("link side not reset");

endmodule

// ==== sec_host_model.sv ====
// sec_host_model: far-end logic that sends dual-port samples on dclk.
// assumes the bench gives a free-running dclk and a mask of bit flips.
`timescale 1ns/1ps
module sec_host_model
  import sec_pkg::*;
(
  input wire logic dclk_i,
  input wire sec_lanes_s flip_i,
  output sec_lanes_s sample_o,
  output sec_lanes_s expect_o
);
  logic [SEC_SAMPLE_W-1:0] pat_r = 14'h1234;

  // odd step walks every bit, so a stuck lane cannot hide
  always @(posedge dclk_i) begin
    pat_r <= pat_r + 14'h0A5B;
  end

  // each lane has its own word; the flip mask injects miscompares
  assign expect_o = '{pat_r, ~pat_r, pat_r ^ 14'h2AAA, pat_r ^ 14'h1555};
  assign sample_o = expect_o ^ flip_i;
endmodule

// ==== tb_top.sv ====
// tb_top: register-level bench for the sample error checker.
// assumes the host model feeds samples and expected words on dclk.
`timescale 1ns/1ps
module tb_top
  import sec_pkg::*;
  ;
  logic mclk_i = 1'b0;
  logic dclk = 1'b0;
  logic reset_i = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  sec_lanes_s flip = '0;
  sec_lanes_s smp;
  sec_lanes_s exp_w;
  int num_errors = 0;
  int checked = 0;

  always #4 mclk_i = ~mclk_i;

  // link clock, ten times the mclk period, at a fixed 1 ns offset from an mclk rising edge
  initial begin
    #13;
    forever #40 dclk = ~dclk;
  end

  sec_host_model host (.dclk_i(dclk), .flip_i(flip), .sample_o(smp),
    .expect_o(exp_w));

  sec_checker DUT (.mclk_i(mclk_i), .reset_i(reset_i), .dclk_i(dclk),
    .sample_i(smp), .expect_i(exp_w), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk_i);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge mclk_i);
    wr = 1'b0;
  endtask

  // read data is sampled a full cycle after the strobe drops
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
    @(negedge mclk_i);
    rd = 1'b1;
    addr = a;
    @(negedge mclk_i);
    rd = 1'b0;
    @(negedge mclk_i);
    chk(rdata, exp);
  endtask

  // a 14-bit vector reads as low byte, then high six bits
  task automatic rd_vec(input logic [7:0] a, input logic [13:0] v);
    rd_reg(a, v[7:0]);
    rd_reg(a + 8'h01, {2'b00, v[13:8]});
  endtask

  // flips change just after a dclk edge so no set is split
  task automatic set_flip(input sec_lanes_s m);
    @(posedge dclk);
    #1 flip = m;
  endtask

  // allows for the sync and handshake latency across domains
  task automatic settle(input int n);
    repeat (n) @(posedge dclk);
    repeat (8) @(posedge mclk_i);
  endtask

  task automatic s_reset();
    for (int a = 'h50; a <= 'h59; a++) begin
      rd_reg(8'(a), 8'h00);
    end
  endtask

  // checking off: a miscompare must leave no trace
  task automatic s_off();
    set_flip(sec_lanes_s'{14'h0010, 14'h0000, 14'h0000, 14'h0000});
    set_flip('0);
    settle(4);
    rd_vec(SEC_A_P0RL, 14'h0000);
    rd_reg(SEC_A_CTRL, 8'h00);
  endtask

  task automatic s_plain();
    wr_reg(SEC_A_CTRL, 8'h80);
    settle(3);
    set_flip(sec_lanes_s'{14'h2108, 14'h0000, 14'h0000, 14'h0001});
    set_flip('0);
    settle(4);
    rd_reg(SEC_A_CTRL, 8'h81);
    rd_vec(SEC_A_P0RL, 14'h2108);
    rd_vec(SEC_A_P1FL, 14'h0001);
    set_flip(sec_lanes_s'{14'h0000, 14'h0400, 14'h0000, 14'h0000});
    set_flip('0);
    settle(4);
    rd_vec(SEC_A_P0RL, 14'h2108);
    rd_vec(SEC_A_P0FL, 14'h0400);
    wr_reg(SEC_A_CTRL, 8'hC0);
    rd_reg(SEC_A_CTRL, 8'h80);
    rd_vec(SEC_A_P0RL, 14'h0000);
    rd_vec(SEC_A_P0FL, 14'h0000);
    wr_reg(SEC_A_CTRL, 8'h84);
    rd_reg(SEC_A_CTRL, 8'h84);
  endtask

  // errors held on, then eight clean sets must clear and pass
  task automatic s_auto();
    wr_reg(SEC_A_CTRL, 8'h20);
    set_flip(sec_lanes_s'{14'h0000, 14'h0000, 14'h3F81, 14'h0000});
    settle(4);
    rd_reg(SEC_A_CTRL, 8'h23);
    rd_vec(SEC_A_P1RL, 14'h3F81);
    set_flip('0);
    settle(12);
    rd_reg(SEC_A_CTRL, 8'h24);
    rd_vec(SEC_A_P1RL, 14'h0000);
  endtask

  // reset in mid-run with errors held on must wipe every flag
  task automatic s_rerst();
    wr_reg(SEC_A_CTRL, 8'h80);
    set_flip(sec_lanes_s'{14'h0000, 14'h0000, 14'h0003, 14'h0000});
    settle(4);
    rd_reg(SEC_A_CTRL, 8'h81);
    rd_vec(SEC_A_P1RL, 14'h0003);
    @(negedge mclk_i);
    reset_i = 1'b1;
    repeat (30) @(negedge mclk_i);
    reset_i = 1'b0;
    set_flip('0);
    settle(4);
    rd_reg(SEC_A_CTRL, 8'h00);
    rd_vec(SEC_A_P1RL, 14'h0000);
  endtask

  task automatic close_out();
    $display("checks %0d, errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // main sequence; reset spans two dclk edges as well
  initial begin
    repeat (20) @(negedge mclk_i);
    reset_i = 1'b0;
    s_reset();
    s_off();
    s_plain();
    s_auto();
    s_rerst();
    close_out();
  end

  // cut a hang short; the run needs only a few microseconds
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule
